// *** lsq_regs_map.vh ***
`ifndef LSQ_REGS_MAP_VH
`define LSQ_REGS_MAP_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define LSQ_ADDR_CONFIG 8'h08
`define LSQ_ADDR_RED_PC 8'h09
`define LSQ_ADDR_GREEN_PC 8'h0A
`define LSQ_ADDR_BLUE_PC 8'h0B
`define LSQ_ADDR_STATUS 8'h0C
`define LSQ_ADDR_SOFT_RESET 8'h0D
`define LSQ_ADDR_PIN_CTRL 8'h0E
`define LSQ_ADDR_MEM_FIRST 8'h10
`define LSQ_ADDR_MEM_LAST 8'h6F

// ----------------------------------------
// reset values and keys
// ----------------------------------------
`define LSQ_RESET_BYTE 8'h00
`define LSQ_SOFT_RESET_KEY 8'hFF

// ----------------------------------------
// field positions
// ----------------------------------------
`define LSQ_CFG_PWM_CLOCK_SELECT 6
`define LSQ_CFG_INT_CLK_EN 0
`define LSQ_CFG_USED_MSB 6
`define LSQ_STAT_EXT_CLK 3
`define LSQ_STAT_RED_IRQ 2
`define LSQ_STAT_GREEN_IRQ 1
`define LSQ_STAT_BLUE_IRQ 0
`define LSQ_PIN_IRQ_AS_OUTPUT 2
`define LSQ_PIN_GENERAL_OUTPUT 1
`define LSQ_PIN_IRQ_LEVEL 0
`define LSQ_PC_WIDTH 4

// ----------------------------------------
// channel codes
// ----------------------------------------
`define LSQ_EXECUTION_CONTROL_HOLD 2'b00
`define LSQ_MODE_LOAD 2'b01

// ----------------------------------------
// timing
// ----------------------------------------
`define LSQ_REF_CLK_HZ 25000000
`define LSQ_SLOW_CLK_HZ 32768
`define LSQ_PWM_LOW_HZ 256
`define LSQ_PWM_HIGH_HZ 558
`define LSQ_SLOW_PER_LOW_PWM (`LSQ_SLOW_CLK_HZ / `LSQ_PWM_LOW_HZ)
`define LSQ_REF_PER_HIGH_PWM (`LSQ_REF_CLK_HZ / `LSQ_PWM_HIGH_HZ)
`define LSQ_REF_PER_SLOW (`LSQ_REF_CLK_HZ / `LSQ_SLOW_CLK_HZ)

`endif

// *** lsq_pwm_clk.v ***
`include "lsq_regs_map.vh"

module lsq_pwm_clk #(
    parameter HIGH_DIV = `LSQ_REF_PER_HIGH_PWM,
    parameter LOW_DIV = `LSQ_SLOW_PER_LOW_PWM
) (
    // clock and reset
    input wire ref_clk,
    input wire nrst,
    input wire softClear,
    // rate selection
    input wire pwmClockSelect,
    input wire slowTick,
    // pwm tick
    output reg pwmTick
);

    // ----------------------------------------
    // two dividers, one per pwm source
    // ----------------------------------------
    reg [15:0] highCnt_r;
    reg [7:0] lowCnt_r;
    wire highWrap;
    wire lowWrap;

    assign highWrap = (highCnt_r == HIGH_DIV[15:0] - 16'h0001);
    assign lowWrap = slowTick && (lowCnt_r == LOW_DIV[7:0] - 8'h01);

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            highCnt_r <= 16'h0000;
            lowCnt_r <= 8'h00;
            pwmTick <= 1'b0;
        end else if (softClear) begin
            highCnt_r <= 16'h0000;
            lowCnt_r <= 8'h00;
            pwmTick <= 1'b0;
        end else begin
            highCnt_r <= highWrap ? 16'h0000 : highCnt_r + 16'h0001;
            if (slowTick) begin
                lowCnt_r <= lowWrap ? 8'h00 : lowCnt_r + 8'h01;
            end
            pwmTick <= pwmClockSelect ? highWrap : lowWrap; // R01
        end
    end

endmodule

// *** lsq_prog_mem.v ***
`include "lsq_regs_map.vh"

module lsq_prog_mem #(
    parameter DEPTH = 96,
    parameter AW = 7
) (
    // clock and reset
    input wire ref_clk,
    input wire nrst,
    input wire softClear,
    // write port
    input wire wrEn,
    input wire [AW-1:0] wrAddr,
    input wire [7:0] wrData,
    // read ports
    input wire [AW-1:0] hostAddr,
    output wire [7:0] hostData,
    input wire [AW-1:0] engAddr,
    output wire [7:0] engData
);

    // ----------------------------------------
    // byte array, cleared on any reset
    // ----------------------------------------
    reg [7:0] mem [0:DEPTH-1];
    integer i;

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem[i] <= `LSQ_RESET_BYTE; // R12
            end
        end else if (softClear) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem[i] <= `LSQ_RESET_BYTE;
            end
        end else if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    assign hostData = (hostAddr < DEPTH) ? mem[hostAddr] : 8'h00;
    assign engData = (engAddr < DEPTH) ? mem[engAddr] : 8'h00;

endmodule

// *** lsq_regs.v ***
// Contract
// R01: pwm tick 256 Hz slow, 558 Hz internal
// R02: three 4-bit program counters, upper bits zero
// R03: host spaces counter writes over 153 us
// R04: counter access only while channel holds
// R05: status bit 3 shows external clock use
// R06: status bits 2..0 are channel interrupt flags
// R07: status read clears all interrupt flags
// R08: status read releases the interrupt pin
// R09: FFH to reset register resets all, no ack
// R10: control bit 2 makes irq pin general output
// R11: general pin follows bit 1, irq bit 0
// R12: program memory bytes 10H..6FH, reset 00H
// R13: execution code 00b is hold state
// R14: load mode enables memory writes, clears counter
// R15: irq pin low while any flag set
// R16: other reset values leave registers untouched
`include "lsq_regs_map.vh"

module lsq_regs #(
    parameter HIGH_DIV = `LSQ_REF_PER_HIGH_PWM,
    parameter SLOW_DIV = `LSQ_REF_PER_SLOW
) (
    // clock and reset
    input wire ref_clk,
    input wire nrst,
    // register port from the two-wire host
    input wire regWrite,
    input wire regRead,
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    output reg [7:0] regRdData,
    output reg regAck,
    // channel engine side
    input wire [5:0] executionControl,
    input wire [5:0] operationMode,
    input wire [2:0] chanIrqEvent,
    input wire [6:0] engMemAddr,
    output reg [7:0] engMemData,
    output reg [11:0] programCounters,
    // clocks
    input wire slowClockInput,
    output reg pwmTick,
    // pins
    output reg generalOutputPin,
    output reg irqPinLevel
);

    // ----------------------------------------
    // register state
    // ----------------------------------------
    reg [`LSQ_CFG_USED_MSB:0] config_r;
    reg [3:0] pc_r [0:2];
    reg [3:0] pcPend_r [0:2];
    reg [2:0] pcPendValid_r;
    reg [2:0] irqFlags_r;
    reg [2:0] pinCtrl_r;
    reg slowPrev_r;
    reg [9:0] slowDiv_r;
    reg softClear;
    wire slowEdge;
    wire intSlowTick;
    wire slowTick;
    wire extClockInUse;
    wire inHold0;
    wire inHold1;
    wire inHold2;
    wire [2:0] chanHold;
    wire [2:0] chanLoad;
    wire isMem;
    wire memWr;
    wire [6:0] memIdx;
    wire [7:0] memOff;
    wire [7:0] memHostData;
    wire [7:0] memEngData;
    wire pwmTickW;
    wire statusRead;
    wire [2:0] irqFlags_nxt;
    reg [7:0] rdMux;
    integer c;

    // ----------------------------------------
    // helper functions
    // ----------------------------------------
    function isHold;
        input [1:0] code;
        begin
            isHold = (code == `LSQ_EXECUTION_CONTROL_HOLD); // R13
        end
    endfunction

    function [1:0] chanField;
        input [5:0] packed6;
        input [1:0] ch;
        begin
            case (ch)
                2'h0: chanField = packed6[5:4];
                2'h1: chanField = packed6[3:2];
                default: chanField = packed6[1:0];
            endcase
        end
    endfunction

    // ----------------------------------------
    // 32 kHz timebase
    // ----------------------------------------
    assign extClockInUse = ~config_r[`LSQ_CFG_INT_CLK_EN];
    assign slowEdge = slowClockInput & ~slowPrev_r;
    assign intSlowTick = (slowDiv_r == SLOW_DIV[9:0] - 10'h001);
    assign slowTick = extClockInUse ? slowEdge : intSlowTick;

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            slowPrev_r <= 1'b0;
            slowDiv_r <= 10'h000;
        end else begin
            slowPrev_r <= slowClockInput;
            slowDiv_r <= intSlowTick ? 10'h000 : slowDiv_r + 10'h001;
        end
    end

    // ----------------------------------------
    // decode
    // ----------------------------------------
    assign inHold0 = isHold(chanField(executionControl, 2'h0));
    assign inHold1 = isHold(chanField(executionControl, 2'h1));
    assign inHold2 = isHold(chanField(executionControl, 2'h2));
    assign chanHold = {inHold2, inHold1, inHold0};
    assign chanLoad[0] = (chanField(operationMode, 2'h0) == `LSQ_MODE_LOAD);
    assign chanLoad[1] = (chanField(operationMode, 2'h1) == `LSQ_MODE_LOAD);
    assign chanLoad[2] = (chanField(operationMode, 2'h2) == `LSQ_MODE_LOAD);
    assign isMem = (regAddr >= `LSQ_ADDR_MEM_FIRST) && (regAddr <= `LSQ_ADDR_MEM_LAST);
    assign memOff = regAddr - `LSQ_ADDR_MEM_FIRST;
    assign memIdx = memOff[6:0];
    assign memWr = regWrite && isMem && (|chanLoad); // R14
    assign statusRead = regRead && (regAddr == `LSQ_ADDR_STATUS);

    // ----------------------------------------
    // program memory and pwm clock
    // ----------------------------------------
    lsq_prog_mem #(
        .DEPTH(96),
        .AW(7)
    ) u_mem (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .softClear(softClear),
        .wrEn(memWr),
        .wrAddr(memIdx),
        .wrData(regWrData),
        .hostAddr(memIdx),
        .hostData(memHostData),
        .engAddr(engMemAddr),
        .engData(memEngData)
    );

    lsq_pwm_clk #(
        .HIGH_DIV(HIGH_DIV),
        .LOW_DIV(`LSQ_SLOW_PER_LOW_PWM)
    ) u_pwm (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .softClear(softClear),
        .pwmClockSelect(config_r[`LSQ_CFG_PWM_CLOCK_SELECT]),
        .slowTick(slowTick),
        .pwmTick(pwmTickW)
    );

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always @* begin
        rdMux = 8'h00;
        if (isMem) begin
            rdMux = memHostData;
        end else begin
            case (regAddr)
                `LSQ_ADDR_CONFIG: rdMux = {1'b0, config_r};
                `LSQ_ADDR_RED_PC: rdMux = inHold0 ? {4'h0, pc_r[0]} : 8'h00; // R04
                `LSQ_ADDR_GREEN_PC: rdMux = inHold1 ? {4'h0, pc_r[1]} : 8'h00;
                `LSQ_ADDR_BLUE_PC: rdMux = inHold2 ? {4'h0, pc_r[2]} : 8'h00;
                `LSQ_ADDR_STATUS: rdMux = {4'h0, extClockInUse, irqFlags_r}; // R05 R06
                `LSQ_ADDR_PIN_CTRL: rdMux = {5'h00, pinCtrl_r};
                default: rdMux = 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // bus answer and soft reset
    // ----------------------------------------
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            regRdData <= 8'h00;
            regAck <= 1'b0;
            softClear <= 1'b0;
        end else begin
            softClear <= regWrite && (regAddr == `LSQ_ADDR_SOFT_RESET)
                && (regWrData == `LSQ_SOFT_RESET_KEY); // R09 R16
            regAck <= (regRead || regWrite) && !(regWrite
                && (regAddr == `LSQ_ADDR_SOFT_RESET)
                && (regWrData == `LSQ_SOFT_RESET_KEY)); // R09
            if (regRead) begin
                regRdData <= rdMux;
            end
        end
    end

    // ----------------------------------------
    // configuration and pin control
    // ----------------------------------------
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            config_r <= 7'h00;
            pinCtrl_r <= 3'h0;
        end else if (softClear) begin
            config_r <= 7'h00;
            pinCtrl_r <= 3'h0;
        end else if (regWrite) begin
            if (regAddr == `LSQ_ADDR_CONFIG) begin
                config_r <= regWrData[`LSQ_CFG_USED_MSB:0];
            end
            if (regAddr == `LSQ_ADDR_PIN_CTRL) begin
                pinCtrl_r <= regWrData[2:0];
            end
        end
    end

    // ----------------------------------------
    // program counters, applied on slow tick
    // ----------------------------------------
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (c = 0; c < 3; c = c + 1) begin
                pc_r[c] <= 4'h0;
                pcPend_r[c] <= 4'h0;
            end
            pcPendValid_r <= 3'b000;
        end else if (softClear) begin
            for (c = 0; c < 3; c = c + 1) begin
                pc_r[c] <= 4'h0;
                pcPend_r[c] <= 4'h0;
            end
            pcPendValid_r <= 3'b000;
        end else begin
            for (c = 0; c < 3; c = c + 1) begin
                if (regWrite && chanHold[c]
                    && (regAddr == `LSQ_ADDR_RED_PC + c[7:0])) begin
                    pcPend_r[c] <= regWrData[`LSQ_PC_WIDTH-1:0]; // R02 R04
                    pcPendValid_r[c] <= 1'b1;
                end else if (slowTick) begin
                    pcPendValid_r[c] <= 1'b0;
                end
                if (chanLoad[c]) begin
                    pc_r[c] <= 4'h0; // R14
                end else if (slowTick && pcPendValid_r[c]) begin
                    pc_r[c] <= pcPend_r[c]; // R03
                end
            end
        end
    end

    // ----------------------------------------
    // interrupt flags, set wins over read clear
    // ----------------------------------------
    assign irqFlags_nxt = (statusRead ? 3'b000 : irqFlags_r) | chanIrqEvent; // R07

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irqFlags_r <= 3'b000;
        end else if (softClear) begin
            irqFlags_r <= 3'b000;
        end else begin
            irqFlags_r <= irqFlags_nxt; // R06
        end
    end

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            generalOutputPin <= 1'b0;
            irqPinLevel <= 1'b1;
            pwmTick <= 1'b0;
            engMemData <= 8'h00;
            programCounters <= 12'h000;
        end else begin
            generalOutputPin <= pinCtrl_r[`LSQ_PIN_GENERAL_OUTPUT]; // R11
            if (pinCtrl_r[`LSQ_PIN_IRQ_AS_OUTPUT]) begin
                irqPinLevel <= pinCtrl_r[`LSQ_PIN_IRQ_LEVEL]; // R10 R11
            end else begin
                irqPinLevel <= ~|irqFlags_r; // R08 R15
            end
            pwmTick <= pwmTickW;
            engMemData <= memEngData;
            programCounters <= {pc_r[0], pc_r[1], pc_r[2]};
        end
    end

endmodule

// *** lsq_regs_props.sv ***
module lsq_regs_props #(
    parameter HIGH_DIV = 50,
    parameter SLOW_DIV = 8
) (
    // clock and reset
    input wire ref_clk,
    input wire nrst,
    // host port
    input wire regWrite,
    input wire regRead,
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire [7:0] regRdData,
    input wire regAck,
    // engine side and pins
    input wire [5:0] executionControl,
    input wire [2:0] chanIrqEvent,
    input wire [11:0] programCounters,
    input wire generalOutputPin,
    input wire irqPinLevel
);
    timeunit 1ns;
    timeprecision 1ps;
    logic gpoMode_r;
    wire softHit = regWrite && regAddr == 8'h0D && regWrData == 8'hFF;
    wire pinWr = regWrite && regAddr == 8'h0E;
    // ----
    // pin mode tracker
    // ----
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            gpoMode_r <= 1'b0;
        end else if (softHit) begin
            gpoMode_r <= 1'b0;
        end else if (pinWr) begin
            gpoMode_r <= regWrData[2];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    sequence statRd;
        regRead && regAddr == 8'h0C && chanIrqEvent == 3'h0;
    endsequence
    sequence pcRdRun;
        regRead && regAddr == 8'h09 && executionControl[5:4] != 2'b00;
    endsequence
    AST_ACK: assert property ((regWrite || regRead) && !softHit |=> regAck)
        else $error("request not acknowledged");
    AST_NOACK_RESET: assert property (softHit |=> !regAck)
        else $error("soft reset acknowledged");
    AST_SOFT_CLEAR: assert property (softHit |-> ##4 programCounters == 12'h000)
        else $error("counters not cleared");
    AST_STATUS_CLR: assert property (statRd ##1 chanIrqEvent == 3'h0 ##1 statRd
        |=> regRdData[2:0] == 3'h0)
        else $error("flags kept after read");
    AST_IRQ_RELEASE: assert property (statRd ##1 (chanIrqEvent == 3'h0 && !gpoMode_r)
        |=> irqPinLevel)
        else $error("irq pin not released");
    AST_IRQ_ASSERT: assert property (chanIrqEvent != 3'h0 && !gpoMode_r
        |-> ##2 !irqPinLevel)
        else $error("irq pin not asserted");
    AST_PC_REFUSE: assert property (pcRdRun |=> regRdData == 8'h00)
        else $error("counter read outside hold");
    AST_PIN_OUT: assert property (pinWr |-> ##2 generalOutputPin == $past(regWrData[1], 2))
        else $error("general pin wrong");
    AST_PIN_IRQ: assert property (pinWr && regWrData[2]
        |-> ##2 irqPinLevel == $past(regWrData[0], 2))
        else $error("irq pin output wrong");
endmodule
bind lsq_regs lsq_regs_props #(.HIGH_DIV(HIGH_DIV), .SLOW_DIV(SLOW_DIV)) props_u (
    .ref_clk(ref_clk), .nrst(nrst), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .regAck(regAck),
    .executionControl(executionControl), .chanIrqEvent(chanIrqEvent),
    .programCounters(programCounters), .generalOutputPin(generalOutputPin),
    .irqPinLevel(irqPinLevel)
);

// *** lsq_host_model.sv ***
module lsq_host_model (
    // clock
    input wire ref_clk,
    // request
    output logic regWrite,
    output logic regRead,
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    // answer
    input wire [7:0] regRdData,
    input wire regAck
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
    end
    // one-cycle request, answer taken at the next falling edge
    task automatic xfer(input bit w, input [7:0] a, input [7:0] d,
            output [7:0] q, output logic ack);
        @(negedge ref_clk);
        regWrite = w;
        regRead = !w;
        regAddr = a;
        regWrData = d;
        @(negedge ref_clk);
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
        ack = regAck;
        q = regRdData;
    endtask
    // counter writes wait out 3840 reference cycles, about five slow clock periods
    task automatic pcGap();
        repeat (3840) @(negedge ref_clk);
    endtask
endmodule

// *** tb_top.sv ***
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HDIV = 50;
    localparam int SDIV = 8;
    logic ref_clk, nrst, regWrite, regRead, regAck, slowClockInput, pwmTick, ack;
    logic generalOutputPin, irqPinLevel;
    logic [7:0] regAddr, regWrData, regRdData, engMemData, q;
    logic [5:0] executionControl, operationMode;
    logic [2:0] chanIrqEvent;
    logic [6:0] engMemAddr;
    logic [11:0] programCounters;
    logic [7:0] resAddr [8] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0E, 8'h10, 8'h6F};
    int badCount = 0;
    int checked = 0;
    int n;
    lsq_regs #(.HIGH_DIV(HDIV), .SLOW_DIV(SDIV)) dut_u (
        .ref_clk(ref_clk), .nrst(nrst), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .regAck(regAck),
        .executionControl(executionControl), .operationMode(operationMode),
        .chanIrqEvent(chanIrqEvent), .engMemAddr(engMemAddr), .engMemData(engMemData),
        .programCounters(programCounters), .slowClockInput(slowClockInput),
        .pwmTick(pwmTick), .generalOutputPin(generalOutputPin), .irqPinLevel(irqPinLevel)
    );
    lsq_host_model host_u (
        .ref_clk(ref_clk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .regAck(regAck)
    );
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        slowClockInput = 1'b0;
        forever begin
            repeat (381) @(negedge ref_clk);
            slowClockInput = ~slowClockInput;
        end
    end
    task automatic chk(input string s, input logic [11:0] e, input logic [11:0] g);
        checked++;
        if (g !== e) begin
            badCount++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(input [7:0] a, input [7:0] d, input logic e = 1'b1);
        host_u.xfer(1'b1, a, d, q, ack);
        chk("ack", {11'h0, e}, {11'h0, ack});
    endtask
    task automatic rd(input [7:0] a, input [7:0] e);
        host_u.xfer(1'b0, a, 8'h00, q, ack);
        chk("ack", 12'h001, {11'h0, ack});
        chk($sformatf("reg %h", a), {4'h0, e}, {4'h0, q});
    endtask
    task automatic pins(input logic g, input logic i);
        chk("gpo pin", {11'h0, g}, {11'h0, generalOutputPin});
        chk("irq pin", {11'h0, i}, {11'h0, irqPinLevel});
    endtask
    task automatic tickGap(output int c);
        repeat (3000) if (pwmTick !== 1'b1) @(negedge ref_clk);
        @(negedge ref_clk);
        c = 1;
        while (pwmTick !== 1'b1 && c < 3000) begin
            @(negedge ref_clk);
            c++;
        end
    endtask
    task automatic giveVerdict();
        $display("comparisons %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #2400000;
        badCount++;
        giveVerdict();
    end
    initial begin
        nrst = 1'b0;
        executionControl = 6'h00;
        operationMode = 6'h00;
        chanIrqEvent = 3'h0;
        engMemAddr = 7'h00;
        repeat (3) @(negedge ref_clk);
        nrst = 1'b1;
        pins(1'b0, 1'b1);
        for (int i = 0; i < 8; i++) rd(resAddr[i], resAddr[i] == 8'h0C ? 8'h08 : 8'h00);
        rd(8'h0F, 8'h00);
        wr(8'h08, 8'h41);
        rd(8'h0C, 8'h00);
        tickGap(n);
        tickGap(n);
        chk("fast pwm gap", 12'(HDIV), 12'(n));
        wr(8'h08, 8'h01);
        tickGap(n);
        tickGap(n);
        chk("slow pwm gap", 12'(128 * SDIV), 12'(n));
        wr(8'h09, 8'h5A);
        host_u.pcGap();
        wr(8'h0A, 8'hF3);
        host_u.pcGap();
        wr(8'h0B, 8'h0C);
        host_u.pcGap();
        chk("counters", 12'hA3C, programCounters);
        rd(8'h09, 8'h0A);
        rd(8'h0A, 8'h03);
        for (int i = 1; i < 4; i++) begin
            executionControl = 6'(i << 4);
            rd(8'h09, 8'h00);
        end
        wr(8'h09, 8'h01);
        host_u.pcGap();
        executionControl = 6'h00;
        rd(8'h09, 8'h0A);
        operationMode = 6'h10;
        repeat (20) @(negedge ref_clk);
        chk("counters", 12'h03C, programCounters);
        wr(8'h10, 8'hA5);
        wr(8'h6F, 8'h3C);
        rd(8'h10, 8'hA5);
        rd(8'h6F, 8'h3C);
        engMemAddr = 7'h5F;
        operationMode = 6'h00;
        repeat (20) @(negedge ref_clk);
        chk("engine byte", 12'h03C, {4'h0, engMemData});
        wr(8'h11, 8'h77);
        rd(8'h11, 8'h00);
        wr(8'h0E, 8'h06);
        @(negedge ref_clk);
        pins(1'b1, 1'b0);
        wr(8'h0E, 8'h05);
        @(negedge ref_clk);
        pins(1'b0, 1'b1);
        rd(8'h0E, 8'h05);
        wr(8'h0E, 8'h00);
        for (int i = 0; i < 3; i++) begin
            chanIrqEvent = 3'(1 << i);
            @(negedge ref_clk);
            chanIrqEvent = 3'h0;
            @(negedge ref_clk);
            pins(1'b0, 1'b0);
            rd(8'h0C, 8'(1 << i));
            @(negedge ref_clk);
            pins(1'b0, 1'b1);
        end
        chanIrqEvent = 3'h7;
        @(negedge ref_clk);
        chanIrqEvent = 3'h0;
        rd(8'h0C, 8'h07);
        rd(8'h0C, 8'h00);
        wr(8'h0E, 8'h02);
        wr(8'h0D, 8'hFE);
        rd(8'h0E, 8'h02);
        wr(8'h0D, 8'hFF, 1'b0);
        repeat (2) @(negedge ref_clk);
        rd(8'h0E, 8'h00);
        rd(8'h0C, 8'h08);
        rd(8'h10, 8'h00);
        chk("counters", 12'h000, programCounters);
        pins(1'b0, 1'b1);
        wr(8'h0B, 8'h07);
        host_u.pcGap();
        chk("counters", 12'h007, programCounters);
        giveVerdict();
    end
endmodule
